// ==== dsp_status_pkg.sv ====
package dsp_status_pkg;
	// Register selects on the data memory data bus.
	localparam logic [2:0] SEL_ARITH = 3'h0;
	localparam logic [2:0] SEL_STACK = 3'h1;
	localparam logic [2:0] SEL_MODE = 3'h2;
	localparam logic [2:0] SEL_CONFIG = 3'h3;
	localparam logic [2:0] SEL_MASK = 3'h4;
	localparam logic [2:0] SEL_SETCLR = 3'h5;
	// Arithmetic flag positions.
	localparam int F_ZERO = 0;
	localparam int F_NEG = 1;
	localparam int F_OVF = 2;
	localparam int F_CARRY = 3;
	localparam int F_XSIGN = 4;
	localparam int F_QUOT = 5;
	localparam int F_MACOVF = 6;
	localparam int F_SHSIGN = 7;
	// Mode flag positions.
	localparam int M_BANK = 0;
	localparam int M_MIRROR = 1;
	localparam int M_LATCH = 2;
	localparam int M_SAT = 3;
	localparam int M_PLACE = 4;
	localparam int M_TIMER = 5;
	localparam int M_GO = 6;
	// ALU operation kinds.
	localparam logic [1:0] ALU_PLAIN = 2'h0;
	localparam logic [1:0] ALU_MAG = 2'h1;
	localparam logic [1:0] ALU_DIV = 2'h2;
	localparam logic [1:0] ALU_XFER = 2'h3;
	// Condition vector positions.
	localparam int C_EQ = 0;
	localparam int C_NE = 1;
	localparam int C_LT = 2;
	localparam int C_GE = 3;
	localparam int C_LE = 4;
	localparam int C_GT = 5;
	localparam int C_CARRY = 6;
	localparam int C_NCARRY = 7;
	localparam int C_OVF = 8;
	localparam int C_NOVF = 9;
	localparam int C_MACOVF = 10;
	localparam int C_NMACOVF = 11;
	localparam int C_NEG = 12;
	localparam int C_POS = 13;
	localparam int C_NCE = 14;
	localparam int C_TRUE = 15;
	// Reset values and saturation limits.
	localparam logic [7:0] ARITH_RST = 8'h00;
	localparam logic [6:0] MODE_RST = 7'h00;
	localparam logic [9:0] MASK_RST = 10'h000;
	localparam logic [4:0] CONFIG_RST = 5'h00;
	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;
endpackage : dsp_status_pkg

// ==== dsp_status_mode_condition.sv ====
`timescale 1ns/1ns
// How it works
// - Every status and mode register is bus readable and writable; stack flags read-only, set/clear write-only.
// - Interrupt entry pushes arith, mode and mask flags; return pops them.
// - Arithmetic flags are eight bits, condition flags active high.
// - New status lands at cycle end; conditions see it next cycle.
// - Bus writes to data unit registers never touch arithmetic flags.
// - Transfer op sets zero and negative from operand and clears carry.
// - Zero, negative, overflow, carry skip divides; sign on magnitude; quotient on divides.
// - MAC overflow skips clamp; shifter sign only on block scale detect.
// - Stack flags are eight active-high bits covering four stacks.
// - Empty flag set while pops reach or exceed pushes.
// - Overflow sets beyond depth; newest pushes are dropped.
// - Overflow flag is sticky until processor reset.
// - Mode flags change by set and clear instructions or register move.
// - Mirror mode reverses first address generator output bits.
// - Bank select picks primary at zero, secondary at one.
// - Latch mode keeps overflow set until a zero is written.
// - Saturation mode clamps overflowing result to 0x7fff or 0x8000.
// - Timer enable bit starts and stops the timer.
// - Go mode lets core run internally during bus grant.
// - Sixteen conditions from arithmetic flags and the loop counter.
// - Less-than is negative xor overflow; less-or-equal adds zero.
// - Jumps and calls may test the last flag input sample.
module dsp_status_mode_condition #(
	parameter int STAT_DEPTH = 10,
	parameter int PC_DEPTH = 16,
	parameter int CNT_DEPTH = 4,
	parameter int LOOP_DEPTH = 4,
	parameter int ADDR_W = 14
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [2:0] reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] data_memory_data_bus,
	output logic [15:0] reg_rdata,
	input wire logic alu_valid,
	input wire logic [1:0] alu_kind,
	input wire logic [5:0] alu_status,
	input wire logic [15:0] alu_raw_result,
	input wire logic mac_valid,
	input wire logic mac_result_clamp,
	input wire logic mac_ovf,
	input wire logic shifter_block_scale_detect,
	input wire logic shifter_sign,
	input wire logic [2:0] stack_push,
	input wire logic [2:0] stack_pop,
	input wire logic irq_enter,
	input wire logic [9:0] irq_entry_mask,
	input wire logic interrupt_return,
	input wire logic mode_set_instr,
	input wire logic mode_clear_instr,
	input wire logic [6:0] mode_bits,
	input wire logic counter_expired,
	input wire logic flag_input_pin,
	input wire logic [ADDR_W-1:0] address_generator_one,
	output logic [ADDR_W-1:0] dm_address,
	output logic [15:0] alu_result_reg,
	output logic [15:0] conditions,
	output logic [1:0] flag_conditions,
	output logic [7:0] arith_flags,
	output logic [6:0] mode_flags,
	output logic [9:0] interrupt_enable_mask,
	output logic [4:0] interrupt_config,
	output logic [15:0] interrupt_set_clear,
	output logic set_clear_strobe,
	output logic alternate_bank_select,
	output logic timer_run,
	output logic go_mode
);
	localparam int ENT_W = 25;

	typedef struct packed {
		logic [7:0] arith;
		logic [6:0] mode;
		logic [9:0] mask;
		logic [4:0] cfg;
		logic [3:0][5:0] cnt;
		logic [3:0] ovf;
		logic [STAT_DEPTH-1:0][ENT_W-1:0] stk;
		logic [15:0] rd;
		logic [15:0] setclr;
		logic setclr_v;
		logic [15:0] cond;
		logic [1:0] fcond;
		logic [ADDR_W-1:0] addr;
		logic [15:0] result;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic [ADDR_W-1:0] mirror(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = '0;
		for (int k = 0; k < ADDR_W; k++) begin
			r[k] = a[ADDR_W-1-k];
		end
		return r;
	endfunction : mirror

	function automatic logic [5:0] depth_of(input int i);
		unique case (i)
			0: return 6'(PC_DEPTH);
			1: return 6'(CNT_DEPTH);
			2: return 6'(STAT_DEPTH);
			default: return 6'(LOOP_DEPTH);
		endcase
	endfunction : depth_of

	function automatic logic [7:0] stack_word(input state_t s);
		logic [7:0] w;
		w = '0;
		for (int i = 0; i < 4; i++) begin
			w[2*i] = (s.cnt[i] == 6'h00);
			w[2*i+1] = s.ovf[i];
		end
		return w;
	endfunction : stack_word

	logic [3:0] push;
	logic [3:0] pop;
	assign push = {stack_push[2], irq_enter, stack_push[1:0]};
	assign pop = {stack_pop[2], interrupt_return, stack_pop[1:0]};

	always_comb begin
		logic sx;
		logic [ENT_W-1:0] top;
		logic [7:0] f;
		sx = 1'b0;
		top = '0;
		f = '0;
		s_d = s_q;
		s_d.setclr_v = 1'b0;
		// Only operation strobes, bus writes to the flags register and interrupt returns reach the flags; data register loads have no path here.
		if (alu_valid) begin
			if (alu_kind != dsp_status_pkg::ALU_DIV) begin
				s_d.arith[dsp_status_pkg::F_ZERO] = alu_status[dsp_status_pkg::F_ZERO];
				s_d.arith[dsp_status_pkg::F_NEG] = alu_status[dsp_status_pkg::F_NEG];
				s_d.arith[dsp_status_pkg::F_CARRY] = (alu_kind == dsp_status_pkg::ALU_XFER)
					? 1'b0 : alu_status[dsp_status_pkg::F_CARRY];
				s_d.arith[dsp_status_pkg::F_OVF] = (s_q.mode[dsp_status_pkg::M_LATCH]
					& s_q.arith[dsp_status_pkg::F_OVF])
					| alu_status[dsp_status_pkg::F_OVF];
				// A wrapped result has the wrong sign, so its msb tells which rail to use.
				if (s_q.mode[dsp_status_pkg::M_SAT] && alu_status[dsp_status_pkg::F_OVF]) begin
					s_d.result = alu_raw_result[15] ? dsp_status_pkg::SAT_POS
						: dsp_status_pkg::SAT_NEG;
				end else begin
					s_d.result = alu_raw_result;
				end
			end
			if (alu_kind == dsp_status_pkg::ALU_MAG) begin
				s_d.arith[dsp_status_pkg::F_XSIGN] = alu_status[dsp_status_pkg::F_XSIGN];
			end
			if (alu_kind == dsp_status_pkg::ALU_DIV) begin
				s_d.arith[dsp_status_pkg::F_QUOT] = alu_status[dsp_status_pkg::F_QUOT];
			end
		end
		if (mac_valid && !mac_result_clamp) begin
			s_d.arith[dsp_status_pkg::F_MACOVF] = mac_ovf;
		end
		if (shifter_block_scale_detect) begin
			s_d.arith[dsp_status_pkg::F_SHSIGN] = shifter_sign;
		end
		if (reg_wr) begin
			unique case (reg_sel)
				dsp_status_pkg::SEL_ARITH: s_d.arith = data_memory_data_bus[7:0];
				dsp_status_pkg::SEL_MODE: s_d.mode = data_memory_data_bus[6:0];
				dsp_status_pkg::SEL_CONFIG: s_d.cfg = data_memory_data_bus[4:0];
				dsp_status_pkg::SEL_MASK: s_d.mask = data_memory_data_bus[9:0];
				dsp_status_pkg::SEL_SETCLR: begin
					s_d.setclr = data_memory_data_bus;
					s_d.setclr_v = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (mode_set_instr) begin
			s_d.mode = s_d.mode | mode_bits;
		end
		if (mode_clear_instr) begin
			s_d.mode = s_d.mode & ~mode_bits;
		end
		if (irq_enter && s_q.cnt[2] < 6'(STAT_DEPTH)) begin
			s_d.stk[s_q.cnt[2][3:0]] = {s_q.arith, s_q.mode, s_q.mask};
		end
		if (irq_enter) begin
			s_d.mask = irq_entry_mask;
		end
		if (interrupt_return && s_q.cnt[2] != 6'h00 && s_q.cnt[2] <= 6'(STAT_DEPTH)) begin
			top = s_q.stk[4'(s_q.cnt[2] - 6'h01)];
			{s_d.arith, s_d.mode, s_d.mask} = top;
		end
		for (int i = 0; i < 4; i++) begin
			if (push[i] && !pop[i] && s_q.cnt[i] != 6'h3f) begin
				s_d.cnt[i] = s_q.cnt[i] + 6'h01;
				if (s_q.cnt[i] >= depth_of(i)) begin
					s_d.ovf[i] = 1'b1;
				end
			end else if (pop[i] && !push[i] && s_q.cnt[i] != 6'h00) begin
				s_d.cnt[i] = s_q.cnt[i] - 6'h01;
			end
		end
		if (reg_rd) begin
			unique case (reg_sel)
				dsp_status_pkg::SEL_ARITH: s_d.rd = {8'h00, s_q.arith};
				dsp_status_pkg::SEL_STACK: s_d.rd = {8'h00, stack_word(s_q)};
				dsp_status_pkg::SEL_MODE: s_d.rd = {9'h000, s_q.mode};
				dsp_status_pkg::SEL_CONFIG: s_d.rd = {11'h000, s_q.cfg};
				dsp_status_pkg::SEL_MASK: s_d.rd = {6'h00, s_q.mask};
				default: s_d.rd = 16'h0000;
			endcase
		end
		// Conditions decode the next flags value so they update on the same edge as the flags register.
		f = s_d.arith;
		sx = f[dsp_status_pkg::F_NEG] ^ f[dsp_status_pkg::F_OVF];
		s_d.cond[dsp_status_pkg::C_EQ] = f[dsp_status_pkg::F_ZERO];
		s_d.cond[dsp_status_pkg::C_NE] = ~f[dsp_status_pkg::F_ZERO];
		s_d.cond[dsp_status_pkg::C_LT] = sx;
		s_d.cond[dsp_status_pkg::C_GE] = ~sx;
		s_d.cond[dsp_status_pkg::C_LE] = sx | f[dsp_status_pkg::F_ZERO];
		s_d.cond[dsp_status_pkg::C_GT] = ~(sx | f[dsp_status_pkg::F_ZERO]);
		s_d.cond[dsp_status_pkg::C_CARRY] = f[dsp_status_pkg::F_CARRY];
		s_d.cond[dsp_status_pkg::C_NCARRY] = ~f[dsp_status_pkg::F_CARRY];
		s_d.cond[dsp_status_pkg::C_OVF] = f[dsp_status_pkg::F_OVF];
		s_d.cond[dsp_status_pkg::C_NOVF] = ~f[dsp_status_pkg::F_OVF];
		s_d.cond[dsp_status_pkg::C_MACOVF] = f[dsp_status_pkg::F_MACOVF];
		s_d.cond[dsp_status_pkg::C_NMACOVF] = ~f[dsp_status_pkg::F_MACOVF];
		s_d.cond[dsp_status_pkg::C_NEG] = f[dsp_status_pkg::F_XSIGN];
		s_d.cond[dsp_status_pkg::C_POS] = ~f[dsp_status_pkg::F_XSIGN];
		s_d.cond[dsp_status_pkg::C_NCE] = ~counter_expired;
		s_d.cond[dsp_status_pkg::C_TRUE] = 1'b1;
		s_d.fcond = {~flag_input_pin, flag_input_pin};
		s_d.addr = s_q.mode[dsp_status_pkg::M_MIRROR] ? mirror(address_generator_one)
			: address_generator_one;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.arith <= dsp_status_pkg::ARITH_RST;
			s_q.mode <= dsp_status_pkg::MODE_RST;
			s_q.mask <= dsp_status_pkg::MASK_RST;
			s_q.cfg <= dsp_status_pkg::CONFIG_RST;
			s_q.ovf <= 4'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rd;
	assign dm_address = s_q.addr;
	assign alu_result_reg = s_q.result;
	assign conditions = s_q.cond;
	assign flag_conditions = s_q.fcond;
	assign arith_flags = s_q.arith;
	assign mode_flags = s_q.mode;
	assign interrupt_enable_mask = s_q.mask;
	assign interrupt_config = s_q.cfg;
	assign interrupt_set_clear = s_q.setclr;
	assign set_clear_strobe = s_q.setclr_v;
	assign alternate_bank_select = s_q.mode[dsp_status_pkg::M_BANK];
	assign timer_run = s_q.mode[dsp_status_pkg::M_TIMER];
	assign go_mode = s_q.mode[dsp_status_pkg::M_GO];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_ovf_sticky: assert property (s_q.ovf[1] |=> s_q.ovf[1])
		else $error("count stack overflow flag dropped");
	a_xfer_carry: assert property (alu_valid && alu_kind == dsp_status_pkg::ALU_XFER && !reg_wr
		&& !interrupt_return |=> !arith_flags[dsp_status_pkg::F_CARRY])
		else $error("transfer did not clear carry");
	a_div_zero_hold: assert property (alu_valid && alu_kind == dsp_status_pkg::ALU_DIV
		&& !reg_wr && !interrupt_return
		|=> $stable(arith_flags[dsp_status_pkg::F_ZERO]))
		else $error("divide step changed zero flag");
	a_latch_ovf_hold: assert property (mode_flags[dsp_status_pkg::M_LATCH]
		&& arith_flags[dsp_status_pkg::F_OVF] && !reg_wr && !interrupt_return
		|=> arith_flags[dsp_status_pkg::F_OVF])
		else $error("latched overflow cleared");
	a_sat_rail: assert property (alu_valid && alu_kind != dsp_status_pkg::ALU_DIV
		&& mode_flags[dsp_status_pkg::M_SAT] && alu_status[dsp_status_pkg::F_OVF]
		|=> alu_result_reg == dsp_status_pkg::SAT_POS
		|| alu_result_reg == dsp_status_pkg::SAT_NEG)
		else $error("saturated result off the rails");
	a_mirror_addr: assert property (mode_flags[dsp_status_pkg::M_MIRROR]
		|=> dm_address == mirror($past(address_generator_one)))
		else $error("mirrored address wrong");
	a_lt_cond: assert property (conditions[dsp_status_pkg::C_LT]
		== (arith_flags[dsp_status_pkg::F_NEG] ^ arith_flags[dsp_status_pkg::F_OVF])
		&& conditions[dsp_status_pkg::C_LE]
		== (conditions[dsp_status_pkg::C_LT] | arith_flags[dsp_status_pkg::F_ZERO]))
		else $error("less-than conditions mismatch flags");
	a_irq_restore: assert property (irq_enter && !interrupt_return && !reg_wr && !mode_set_instr
		&& !mode_clear_instr && s_q.cnt[2] < 6'(STAT_DEPTH) ##1 interrupt_return && !irq_enter
		|=> mode_flags == $past(mode_flags, 2))
		else $error("mode flags not restored on return");
	a_empty_flag: assert property (reg_rd && reg_sel == dsp_status_pkg::SEL_STACK
		|=> reg_rdata[4] == ($past(s_q.cnt[2]) == 6'h00))
		else $error("status stack empty flag wrong");

	c_overflow_seen: cover property (s_q.ovf[2] && s_q.cnt[2] == 6'h00);
	c_nested_irq: cover property (irq_enter ##1 irq_enter ##1 interrupt_return);
	c_sat_taken: cover property (alu_valid && mode_flags[dsp_status_pkg::M_SAT]
		&& alu_status[dsp_status_pkg::F_OVF]);
	c_mode_instr: cover property (mode_set_instr ##1 mode_clear_instr);
endmodule : dsp_status_mode_condition

// ==== dsp_status_mode_condition_tb.sv ====
`timescale 1ns/1ns
module dsp_status_mode_condition_tb;
	logic clock, rst_b, reg_wr, reg_rd, alu_valid, mac_valid, mac_result_clamp, mac_ovf;
	logic shifter_block_scale_detect, shifter_sign, irq_enter, interrupt_return;
	logic mode_set_instr, mode_clear_instr, counter_expired, flag_input_pin;
	logic set_clear_strobe, alternate_bank_select, timer_run, go_mode;
	logic [2:0] reg_sel, stack_push, stack_pop;
	logic [1:0] alu_kind, flag_conditions;
	logic [5:0] alu_status;
	logic [6:0] mode_bits, mode_flags;
	logic [7:0] arith_flags;
	logic [9:0] irq_entry_mask, interrupt_enable_mask;
	logic [4:0] interrupt_config;
	logic [13:0] address_generator_one, dm_address;
	logic [15:0] data_memory_data_bus, reg_rdata, alu_raw_result, alu_result_reg;
	logic [15:0] conditions, interrupt_set_clear;
	int n_mismatch;
	int comparisons;

	dsp_status_mode_condition u_dut (.clock, .rst_b, .reg_sel, .reg_wr, .reg_rd,
		.data_memory_data_bus, .reg_rdata, .alu_valid, .alu_kind, .alu_status,
		.alu_raw_result, .mac_valid, .mac_result_clamp, .mac_ovf,
		.shifter_block_scale_detect, .shifter_sign, .stack_push, .stack_pop, .irq_enter,
		.irq_entry_mask, .interrupt_return, .mode_set_instr, .mode_clear_instr, .mode_bits,
		.counter_expired, .flag_input_pin, .address_generator_one, .dm_address,
		.alu_result_reg, .conditions, .flag_conditions, .arith_flags, .mode_flags,
		.interrupt_enable_mask, .interrupt_config, .interrupt_set_clear, .set_clear_strobe,
		.alternate_bank_select, .timer_run, .go_mode);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Every pulse is dropped at the falling edge so none lasts past one sampling edge.
	task automatic step();
		@(posedge clock);
		@(negedge clock);
		{reg_wr, reg_rd, alu_valid, mac_valid, shifter_block_scale_detect} = '0;
		{stack_push, stack_pop, irq_enter, interrupt_return} = '0;
		{mode_set_instr, mode_clear_instr} = '0;
	endtask : step

	task automatic wr(input logic [2:0] s, input logic [15:0] d);
		reg_sel = s;
		data_memory_data_bus = d;
		reg_wr = 1'b1;
		step();
	endtask : wr

	task automatic rd(input logic [2:0] s, input logic [15:0] e);
		reg_sel = s;
		reg_rd = 1'b1;
		step();
		chk(reg_rdata, e);
	endtask : rd

	task automatic alu(input logic [1:0] k, input logic [5:0] st, input logic [15:0] raw,
		input logic [7:0] e);
		alu_valid = 1'b1;
		alu_kind = k;
		alu_status = st;
		alu_raw_result = raw;
		step();
		chk(16'(arith_flags), 16'(e));
	endtask : alu

	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end

	initial begin
		n_mismatch = 0;
		comparisons = 0;
		rst_b = 1'b0;
		{reg_wr, reg_rd, alu_valid, mac_valid, shifter_block_scale_detect} = '0;
		{stack_push, stack_pop, irq_enter, interrupt_return} = '0;
		{mode_set_instr, mode_clear_instr, mac_result_clamp, mac_ovf, shifter_sign} = '0;
		{reg_sel, alu_kind, alu_status, mode_bits, irq_entry_mask} = '0;
		{data_memory_data_bus, alu_raw_result, counter_expired, flag_input_pin} = '0;
		address_generator_one = 14'h0001;
		repeat (12) @(negedge clock);
		rst_b = 1'b1;
		step();
		rd(dsp_status_pkg::SEL_STACK, 16'h0055);
		rd(dsp_status_pkg::SEL_ARITH, 16'h0000);
		chk(16'(dm_address), 16'h0001);
		wr(dsp_status_pkg::SEL_MODE, 16'h0020);
		chk(16'({mode_flags, timer_run}), 16'h0041);
		wr(dsp_status_pkg::SEL_MODE, 16'h0000);
		chk(16'(timer_run), 16'h0000);
		wr(dsp_status_pkg::SEL_STACK, 16'h00ff);
		rd(dsp_status_pkg::SEL_STACK, 16'h0055);
		wr(dsp_status_pkg::SEL_SETCLR, 16'h1234);
		chk({interrupt_set_clear[14:0], set_clear_strobe}, 16'h2469);
		rd(dsp_status_pkg::SEL_SETCLR, 16'h0000);
		wr(dsp_status_pkg::SEL_CONFIG, 16'h0015);
		chk(16'(interrupt_config), 16'h0015);
		rd(dsp_status_pkg::SEL_CONFIG, 16'h0015);
		wr(dsp_status_pkg::SEL_ARITH, 16'h005a);
		rd(dsp_status_pkg::SEL_ARITH, 16'h005a);
		wr(dsp_status_pkg::SEL_ARITH, 16'h0000);
		// Condition order below is less, greater-or-equal, less-or-equal, greater.
		alu(dsp_status_pkg::ALU_PLAIN, 6'h02, 16'h0000, 8'h02);
		chk(16'({conditions[2], conditions[3], conditions[4], conditions[5]}), 16'ha);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h01, 16'h0000, 8'h01);
		chk(16'({conditions[2], conditions[3], conditions[4], conditions[5]}), 16'h6);
		chk(16'({conditions[0], conditions[1]}), 16'h2);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h08, 16'h0000, 8'h08);
		alu(dsp_status_pkg::ALU_XFER, 6'h0a, 16'h0000, 8'h02);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h01, 16'h0000, 8'h01);
		alu(dsp_status_pkg::ALU_DIV, 6'h2e, 16'h0000, 8'h21);
		alu(dsp_status_pkg::ALU_MAG, 6'h10, 16'h0000, 8'h30);
		chk(16'({conditions[12], conditions[13]}), 16'h2);
		mac_valid = 1'b1;
		mac_ovf = 1'b1;
		step();
		chk(16'(arith_flags), 16'h0070);
		mac_valid = 1'b1;
		mac_ovf = 1'b0;
		mac_result_clamp = 1'b1;
		step();
		chk(16'(arith_flags), 16'h0070);
		mac_result_clamp = 1'b0;
		shifter_block_scale_detect = 1'b1;
		shifter_sign = 1'b1;
		step();
		chk(16'({arith_flags, conditions[10]}), 16'h01e1);
		wr(dsp_status_pkg::SEL_MODE, 16'h0008);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h04, 16'h8001, 8'hf4);
		chk(alu_result_reg, 16'h7fff);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h04, 16'h0001, 8'hf4);
		chk(alu_result_reg, 16'h8000);
		wr(dsp_status_pkg::SEL_MODE, 16'h0000);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h04, 16'h1234, 8'hf4);
		chk(alu_result_reg, 16'h1234);
		wr(dsp_status_pkg::SEL_MODE, 16'h0004);
		wr(dsp_status_pkg::SEL_ARITH, 16'h0000);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h04, 16'h0000, 8'h04);
		alu(dsp_status_pkg::ALU_PLAIN, 6'h00, 16'h0000, 8'h04);
		chk(16'(conditions[8]), 16'h0001);
		wr(dsp_status_pkg::SEL_ARITH, 16'h0000);
		chk(16'(arith_flags), 16'h0000);
		repeat (5) begin
			stack_push = 3'h2;
			step();
		end
		rd(dsp_status_pkg::SEL_STACK, 16'h0059);
		repeat (5) begin
			stack_pop = 3'h2;
			step();
		end
		rd(dsp_status_pkg::SEL_STACK, 16'h005d);
		wr(dsp_status_pkg::SEL_MASK, 16'h03ff);
		wr(dsp_status_pkg::SEL_MODE, 16'h0001);
		wr(dsp_status_pkg::SEL_ARITH, 16'h0003);
		irq_enter = 1'b1;
		step();
		chk(16'(interrupt_enable_mask), 16'h0000);
		rd(dsp_status_pkg::SEL_STACK, 16'h004d);
		wr(dsp_status_pkg::SEL_ARITH, 16'h0000);
		wr(dsp_status_pkg::SEL_MODE, 16'h0000);
		interrupt_return = 1'b1;
		step();
		step();
		chk(16'({arith_flags, mode_flags, alternate_bank_select}), 16'h0303);
		chk(16'(interrupt_enable_mask), 16'h03ff);
		wr(dsp_status_pkg::SEL_MODE, 16'h0002);
		step();
		chk(16'(dm_address), 16'h2000);
		mode_set_instr = 1'b1;
		mode_bits = 7'h40;
		step();
		chk(16'({mode_flags, go_mode}), 16'h0085);
		mode_clear_instr = 1'b1;
		mode_bits = 7'h42;
		step();
		chk(16'({mode_flags, go_mode}), 16'h0000);
		flag_input_pin = 1'b1;
		step();
		chk(16'(flag_conditions), 16'h0001);
		flag_input_pin = 1'b0;
		counter_expired = 1'b1;
		step();
		step();
		chk(16'({flag_conditions, conditions[14]}), 16'h0004);
		test_done();
	end
endmodule : dsp_status_mode_condition_tb
